/* inc/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
  // Channel count and sample width as seen by the serializer.
  localparam int CH_COUNT = 4;
  localparam int SAMPLE_W = 16;
  // Serialization length codes.
  localparam logic [1:0] SER_16 = 2'h0;
  localparam logic [1:0] SER_14 = 2'h1;
  localparam logic [1:0] SER_12 = 2'h2;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_14 = 5'h0e;
  localparam logic [4:0] BITS_12 = 5'h0c;
  // Serial port frame: read flag, 7-bit address, 8 data bits.
  localparam logic [3:0] SPI_LAST_BIT = 4'hf;
  localparam logic [3:0] SPI_CMD_BIT = 4'h7;
  localparam int REG_COUNT = 2;
  localparam logic [6:0] REG_PWR = 7'h00;
  localparam logic [6:0] REG_OUT = 7'h01;
  localparam logic [6:0] REG_STAT = 7'h02;
  // Field positions.
  localparam int PWR_DOWN_BIT = 0;
  localparam int OUT_TWO_BIT = 0;
  localparam int OUT_SER_LSB = 1;
  localparam int OUT_ILOW_BIT = 3;
  localparam int OUT_TERM_BIT = 4;
  // Reset values: powered up, two lanes, 16-bit, full current.
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h01;
  // Pin vector positions after the synchroniser.
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_SDO = 3;
  localparam int PIN_PAR = 4;

  // Bits per lane per sample for a length code and lane count.
  function automatic logic [4:0] frame_bits(logic [1:0] ser,
                                            logic two);
    logic [4:0] b;
    b = (ser == SER_14) ? BITS_14 :
        (ser == SER_12) ? BITS_12 : BITS_16;
    return two ? (b >> 1) : b;
  endfunction
endpackage

/* rtl/quad_adc_ctrl.sv */
// Notes on behaviour
// - a conversion starts on encode rising edge, i.e. complement falling.
// - in serial mode clock edges shift data only while select is low.
// - input bits are captured on the rising serial clock edge.
// - readback shifts register bits out; host latches on falling edge.
// - readback output is open drain, pulls low only; may be unused.
// - mode pin low gives serial port; high makes the pins static inputs.
// - parallel mode: select pin level picks two-lane or one-lane output.
// - parallel mode: clock pin level picks output drive current.
// - parallel mode: data input pin high powers the part down.
// - parallel mode: readback pin enables output pair termination.
// - one-lane mode uses only lane A; lane B of each channel is off.
// - in serial mode both lane modes offer 16, 14 or 12 bits per sample; parallel mode uses 16.
// - two lanes at 14 bits gives frame period of two encode periods.
// - four channels with two lanes each, shared frame and data clock.
// - serial bit period must not be below the minimum bit period.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
module quad_adc_ctrl #(
  parameter int CH = adc_ctrl_pkg::CH_COUNT,
  parameter int SW = adc_ctrl_pkg::SAMPLE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic programming_mode_select_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic power_down_o,
  output logic two_lane_o,
  output logic drive_low_current_o,
  output logic term_en_o,
  input wire logic lane_clk_i,
  input wire logic encode_clock_pos_i,
  input wire logic encode_clock_neg_i,
  input wire logic [CH*SW-1:0] sample_data_i,
  output logic [CH-1:0] lane_a_o,
  output logic [CH-1:0] lane_b_o,
  output logic lane_b_en_o,
  output logic frame_start_out_o,
  output logic serial_data_clock_out_o,
  output logic overrun_o
);

  // ---------------- System clock domain ----------------
  logic [4:0] pin_s1, pin_s2;
  logic sck_d;
  logic [3:0] bit_cnt_r;
  logic [14:0] in_sh_r;
  logic [7:0] rd_sh_r;
  logic rd_r;
  logic [7:0] mode_r [adc_ctrl_pkg::REG_COUNT];
  logic [3:0] cfg_r;
  logic ovr_s1, ovr_s2;
  logic [7:0] stat_w;
  // The overrun flag lives in the lane domain. It is declared here
  // because the system side reads it through its synchroniser below.
  logic ovr_lane_r;

  // Pins pass two flops; the first is read by the second only.
  // The clock pin gets a third stage that serves edge detection only.
  always_ff @(posedge clk_i) begin
    pin_s1 <= {programming_mode_select_i, sdo_i, sdi_i, sck_i, cs_n_i};
    pin_s2 <= pin_s1;
    sck_d <= pin_s2[adc_ctrl_pkg::PIN_SCK];
  end

  wire cs_n = pin_s2[adc_ctrl_pkg::PIN_CS];
  wire sck = pin_s2[adc_ctrl_pkg::PIN_SCK];
  wire sdi = pin_s2[adc_ctrl_pkg::PIN_SDI];
  wire sdo_in = pin_s2[adc_ctrl_pkg::PIN_SDO];
  wire par = pin_s2[adc_ctrl_pkg::PIN_PAR];

  // Serial port edges count only in serial mode with select low.
  wire spi_en = ~par & ~cs_n;
  wire sck_rise = spi_en & sck & ~sck_d;
  wire sck_fall = spi_en & ~sck & sck_d;
  wire [15:0] frame_w = {in_sh_r, sdi};
  wire spi_cmd = sck_rise & (bit_cnt_r == adc_ctrl_pkg::SPI_CMD_BIT);
  wire spi_last = sck_rise & (bit_cnt_r == adc_ctrl_pkg::SPI_LAST_BIT);
  wire spi_wr = spi_last & ~frame_w[15];
  // The count wraps to zero on the sixteenth rise, so a fall with a zero
  // count is the one that follows the last bit of the frame.
  wire rd_done = sck_fall & (bit_cnt_r == 4'h0);

  // Wishbone decode. A request is answered one cycle later, and a write
  // lands at the edge where the master sees ack high, so the register
  // and the bus cycle end together. While ack is up no new request is
  // taken, which keeps ack a single-cycle pulse.
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire [6:0] wb_idx = {1'b0, wb_adr_i[7:2]};

  // Shared write port; the serial port wins a same-cycle clash.
  wire wr_en = spi_wr | wb_wr;
  wire [6:0] wr_addr = spi_wr ? frame_w[14:8] : wb_idx;
  wire [7:0] wr_dat = spi_wr ? frame_w[7:0] : wb_dat_i[7:0];

  // Register read mux shared by readback and the bus.
  function automatic logic [7:0] reg_rd(logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == adc_ctrl_pkg::REG_PWR) begin
      d = mode_r[0];
    end else if (a == adc_ctrl_pkg::REG_OUT) begin
      d = mode_r[1];
    end else if (a == adc_ctrl_pkg::REG_STAT) begin
      d = stat_w;
    end
    return d;
  endfunction

  // Serial input shifter; a frame restarts whenever select rises.
  always_ff @(posedge clk_i) begin
    if (rst_i || !spi_en) begin
      bit_cnt_r <= 4'h0;
      in_sh_r <= 15'h0000;
    end else if (sck_rise) begin
      bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
      in_sh_r <= frame_w[14:0];
    end
  end

  // Mode registers; while select is high only a bus write changes them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r[0] <= adc_ctrl_pkg::PWR_RST;
      mode_r[1] <= adc_ctrl_pkg::OUT_RST;
    end else if (wr_en && wr_addr == adc_ctrl_pkg::REG_PWR) begin
      mode_r[0] <= wr_dat;
    end else if (wr_en && wr_addr == adc_ctrl_pkg::REG_OUT) begin
      mode_r[1] <= wr_dat;
    end
  end

  // Readback: load after the command byte, shift on falling edges.
  // Open drain: pin driven low only for a zero bit, else released.
  // The last bit stays on the pin until the fall after the sixteenth
  // rise, because the host latches it on that fall; releasing it at the
  // rise would hand the host the pull-up level instead.
  always_ff @(posedge clk_i) begin
    sdo_o <= 1'b0;
    if (rst_i || !spi_en || rd_done) begin
      rd_r <= 1'b0;
      rd_sh_r <= 8'h00;
      sdo_oe_n_o <= 1'b1;
    end else if (spi_cmd) begin
      rd_r <= frame_w[7];
      rd_sh_r <= reg_rd(frame_w[6:0]);
    end else if (sck_fall && rd_r) begin
      sdo_oe_n_o <= rd_sh_r[7];
      rd_sh_r <= {rd_sh_r[6:0], 1'b0};
    end
  end

  // Effective settings: pins in parallel mode with length fixed at 16, registers otherwise.
  wire two_w = par ? ~cs_n : mode_r[1][adc_ctrl_pkg::OUT_TWO_BIT];
  wire ilow_w = par ? sck : mode_r[1][adc_ctrl_pkg::OUT_ILOW_BIT];
  wire pdn_w = par ? sdi : mode_r[0][adc_ctrl_pkg::PWR_DOWN_BIT];
  wire term_w = par ? sdo_in : mode_r[1][adc_ctrl_pkg::OUT_TERM_BIT];
  wire [1:0] ser_w = par ? adc_ctrl_pkg::SER_16 :
      mode_r[1][adc_ctrl_pkg::OUT_SER_LSB +: 2];
  assign stat_w = {1'b0, ovr_s2, rd_r, pdn_w, term_w, ilow_w, two_w, par};

  // Registered mode outputs and the bundle sent to the lane side.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      two_lane_o <= 1'b1;
      drive_low_current_o <= 1'b0;
      power_down_o <= 1'b0;
      term_en_o <= 1'b0;
      cfg_r <= {1'b0, adc_ctrl_pkg::SER_16, 1'b1};
    end else begin
      two_lane_o <= two_w;
      drive_low_current_o <= ilow_w;
      power_down_o <= pdn_w;
      term_en_o <= term_w;
      cfg_r <= {pdn_w, ser_w, two_w};
    end
  end

  // Bus slave: ack one cycle after the request, unmapped reads zero.
  // Read data is captured together with ack, so it stands exactly in
  // the cycle in which the master samples ack high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= {24'h00_0000, reg_rd(wb_idx)};
    end
  end

  // Overrun level comes back from the lane side as a level. It is a
  // single bit that changes at most once per frame, so two flops are
  // enough and no handshake is needed.
  always_ff @(posedge clk_i) begin
    ovr_s1 <= ovr_lane_r;
    ovr_s2 <= ovr_s1;
    overrun_o <= ovr_s2;
  end

  // ---------------- Lane clock domain ----------------
  logic rst_l1, rst_l2;
  logic [3:0] cfg_l1, cfg_l2;
  logic pos_s1, pos_s2, neg_s1, neg_s2, enc_q;
  logic [SW-1:0] sh_r [CH];
  logic [4:0] idx_r, len_r;
  logic busy_r, two_cur_r, t14_r, fr_par_r;
  // Single-ended use ties the complement low, so the AND still works.
  wire enc_lvl = pos_s2 & ~neg_s2;

  // Reset, settings and encode pins cross on two flops each. The
  // settings are quasi-static; lane count and length apply at a frame start, power down at once.
  always_ff @(posedge lane_clk_i) begin
    rst_l1 <= rst_i;
    rst_l2 <= rst_l1;
    cfg_l1 <= cfg_r;
    cfg_l2 <= cfg_l1;
    pos_s1 <= encode_clock_pos_i;
    pos_s2 <= pos_s1;
    neg_s1 <= encode_clock_neg_i;
    neg_s2 <= neg_s1;
    enc_q <= enc_lvl;
  end

  wire start = enc_lvl & ~enc_q;
  wire pdn_l = cfg_l2[3];
  wire two_l = cfg_l2[0];
  wire [4:0] len_w = adc_ctrl_pkg::frame_bits(cfg_l2[2:1], two_l);
  wire t14_w = two_l & (cfg_l2[2:1] == adc_ctrl_pkg::SER_14);
  wire last_bit = (idx_r == 5'(len_r - 5'h01));

  // Frame sequencer. A start while the previous frame still runs
  // means the encode rate is too high for the bit rate chosen.
  always_ff @(posedge lane_clk_i) begin
    if (rst_l2) begin
      busy_r <= 1'b0;
      idx_r <= 5'h00;
      len_r <= adc_ctrl_pkg::BITS_16;
      two_cur_r <= 1'b1;
      t14_r <= 1'b0;
      fr_par_r <= 1'b0;
      ovr_lane_r <= 1'b0;
    end else if (start && !pdn_l) begin
      busy_r <= 1'b1;
      idx_r <= 5'h00;
      len_r <= len_w;
      two_cur_r <= two_l;
      t14_r <= t14_w;
      fr_par_r <= ~fr_par_r;
      ovr_lane_r <= busy_r;
    end else if (busy_r) begin
      idx_r <= 5'(idx_r + 5'h01);
      busy_r <= ~last_bit;
    end
  end

  // Per-channel shift registers, MSB first, one or two bits a cycle.
  always_ff @(posedge lane_clk_i) begin
    for (int c = 0; c < CH; c++) begin
      if (start && !pdn_l) begin
        sh_r[c] <= sample_data_i[c*SW +: SW];
      end else if (busy_r) begin
        sh_r[c] <= two_cur_r ? (sh_r[c] << 2) : (sh_r[c] << 1);
      end
    end
  end

  // Lane, frame and data clock outputs, all registered.
  always_ff @(posedge lane_clk_i) begin
    if (rst_l2 || pdn_l) begin
      lane_a_o <= '0;
      lane_b_o <= '0;
      lane_b_en_o <= 1'b0;
      frame_start_out_o <= 1'b0;
      serial_data_clock_out_o <= 1'b0;
    end else begin
      for (int c = 0; c < CH; c++) begin
        lane_a_o[c] <= busy_r & sh_r[c][SW-1];
        lane_b_o[c] <= busy_r & two_cur_r & sh_r[c][SW-2];
      end
      lane_b_en_o <= two_cur_r;
      frame_start_out_o <= t14_r ? fr_par_r :
          (busy_r & (idx_r < (len_r >> 1)));
      serial_data_clock_out_o <= ~serial_data_clock_out_o;
    end
  end

  // ---------------- Checks ----------------
  // Each property is clocked in the domain of the signals it watches and
  // is held off by that domain's own copy of reset.
  a_hold_cs_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cs_n && !wb_wr) |=> ($stable(mode_r[0]) && $stable(mode_r[1])))
    else $error("mode registers changed with select high");
  a_spi_write_cap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (spi_wr && frame_w[14:8] == adc_ctrl_pkg::REG_OUT) |=>
    mode_r[1] == $past(frame_w[7:0]))
    else $error("serial write not captured");
  a_sdo_open_drain: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rd_r |=> sdo_oe_n_o)
    else $error("readback pin pulled low outside readback");
  a_sdo_low_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sdo_o == 1'b0)
    else $error("readback pin driven high");
  a_readback_bit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sck_fall && rd_r && !rd_done) |=> sdo_oe_n_o == $past(rd_sh_r[7]))
    else $error("readback bit wrong");
  a_par_lane_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    par |=> two_lane_o == !$past(cs_n))
    else $error("lane select not from select pin");
  a_par_current: assert property (
    @(posedge clk_i) disable iff (rst_i)
    par |=> drive_low_current_o == $past(sck))
    else $error("current select not from clock pin");
  a_par_pdn_term: assert property (
    @(posedge clk_i) disable iff (rst_i)
    par |=> (power_down_o == $past(sdi)) && (term_en_o == $past(sdo_in)))
    else $error("power down or termination wrong");
  a_wb_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_lane_b_off: assert property (
    @(posedge lane_clk_i) disable iff (rst_l2)
    !lane_b_en_o |-> lane_b_o == '0)
    else $error("lane B active in one-lane mode");
  a_enc_start: assert property (
    @(posedge lane_clk_i) disable iff (rst_l2)
    (start && !pdn_l) |=> busy_r && idx_r == 5'h00)
    else $error("encode edge did not start a frame");
  // Only a start that follows another fourteen-bit two-lane frame is
  // checked: at a mode change the old frame level may already match.
  // A power down in between forces the output low, so it is excused.
  a_fr_double: assert property (
    @(posedge lane_clk_i) disable iff (rst_l2)
    (start && !pdn_l && t14_w && t14_r) |=> ##1
    ($past(pdn_l) || frame_start_out_o != $past(frame_start_out_o)))
    else $error("frame output did not toggle per sample");
  c_spi_write: cover property (@(posedge clk_i) disable iff (rst_i)
    spi_wr);
  c_spi_read: cover property (@(posedge clk_i) disable iff (rst_i)
    sck_fall && rd_r && !sdo_oe_n_o);
  c_one_lane: cover property (@(posedge lane_clk_i) disable iff (rst_l2)
    busy_r && !two_cur_r);
  c_overrun: cover property (@(posedge lane_clk_i) disable iff (rst_l2)
    ovr_lane_r);

endmodule // quad_adc_ctrl

/* test/adc_host_model.sv */
`timescale 1ns/1ps
// Host on the configuration pins: serial master, or static straps.
module adc_host_model (
  input wire logic clk_i,
  input wire logic sdo_line_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  output logic strap_sdo_o
);
  logic idle_r = 1'b1;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    strap_sdo_o = 1'b0;
  end
  // An unused data line wanders, so a stale bit never looks like data.
  always @(posedge clk_i) begin
    if (idle_r) begin
      sdi_o <= ~sdi_o;
    end
  end
  // Sixteen clocks, low 5 and high 3 cycles; sel = 0 keeps select high.
  task automatic xfer(input logic [15:0] f, input logic sel,
                      output logic [7:0] rb);
    @(posedge clk_i);
    idle_r <= 1'b0;
    @(posedge clk_i);
    cs_n_o <= ~sel;
    for (int i = 15; i >= 0; i--) begin
      sdi_o <= f[i];
      repeat (5) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      if (i < 8) begin
        rb[i] = sdo_line_i;
      end
      sck_o <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    cs_n_o <= 1'b1;
    idle_r <= 1'b1;
  endtask
  // Pin levels as {readback, data, clock, select} in parallel mode.
  task automatic strap(input logic [3:0] v);
    @(posedge clk_i);
    idle_r <= 1'b0;
    @(posedge clk_i);
    {strap_sdo_o, sdi_o, sck_o, cs_n_o} <= v;
  endtask
endmodule // adc_host_model

/* test/tb_quad_adc_mode_control_and_lane_select.sv */
`timescale 1ns/1ps
module tb_quad_adc_mode_control_and_lane_select;
  logic clk_i = 1'b0, rst_i = 1'b1, lane_clk = 1'b0, enc = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, par = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, wb_dat_o;
  logic [3:0] sel = 4'h0, lane_a_o, lane_b_o;
  logic [63:0] smp = 64'h0;
  logic cs_n, sck, sdi, strap_sdo, wb_ack_o, sdo_o, sdo_oe_n_o;
  logic power_down_o, two_lane_o, drive_low_current_o, term_en_o;
  logic lane_b_en_o, frame_start_out_o, serial_data_clock_out_o, overrun_o;
  wire sdo_pin;
  int miscompares = 0, check_count = 0, cyc_cnt = 0;
  int fr_cnt, dco_cnt, b_bad, a_act, enc_half = 800;
  // Readback line has a pull-up; in parallel mode the host drives it.
  assign sdo_pin = par ? strap_sdo : (sdo_oe_n_o ? 1'b1 : sdo_o);
  always #10 clk_i = ~clk_i;
  always #32 lane_clk = ~lane_clk;
  always #(enc_half) enc = ~enc;
  // Receiver side counters on the lanes.
  always @(posedge frame_start_out_o) fr_cnt++;
  always @(serial_data_clock_out_o) dco_cnt++;
  always @(posedge lane_clk) begin
    if (lane_b_o !== 4'h0) b_bad++;
    if (lane_a_o !== 4'h0) a_act++;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  quad_adc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .programming_mode_select_i(par), .cs_n_i(cs_n), .sck_i(sck),
    .sdi_i(sdi), .sdo_i(sdo_pin), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
    .power_down_o(power_down_o), .two_lane_o(two_lane_o),
    .drive_low_current_o(drive_low_current_o), .term_en_o(term_en_o),
    .lane_clk_i(lane_clk), .encode_clock_pos_i(enc),
    .encode_clock_neg_i(~enc), .sample_data_i(smp), .lane_a_o(lane_a_o),
    .lane_b_o(lane_b_o), .lane_b_en_o(lane_b_en_o),
    .frame_start_out_o(frame_start_out_o),
    .serial_data_clock_out_o(serial_data_clock_out_o),
    .overrun_o(overrun_o));
  adc_host_model i_host (.clk_i(clk_i), .sdo_line_i(sdo_pin),
    .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi), .strap_sdo_o(strap_sdo));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; waits for the answer under a bounded count.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, sel, adr, wdat} <= {2'h3, w, 4'h1, a, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    q = wb_dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask
  // Legal output register value: length code kept to 16, 14 or 12.
  function automatic logic [7:0] legal_out(logic [31:0] r);
    return {3'h0, r[4:3], 2'(r[2:1] % 3), r[0]};
  endfunction
  function automatic int exp_fr(logic two, logic [1:0] s, int n);
    return (two && s == adc_ctrl_pkg::SER_14) ? n / 2 : n;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] d, rb;
    logic [31:0] q;
    logic [6:0] a;
    logic two;
    logic [1:0] s;
    q = $urandom(45010);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("two_lane_rst", 1, two_lane_o);
    chk("oe_n_rst", 1, sdo_oe_n_o);
    wb(0, 8'h04, 8'h00, q);
    chk("out_reg_rst", adc_ctrl_pkg::OUT_RST, q);
    wb(0, 8'h40, 8'h00, q);
    chk("unmapped", 0, q);
    $display("test reset done");
    // Random traffic, written on one path and read on the other.
    for (int k = 0; k < 6; k++) begin
      a = 7'($urandom_range(1, 0));
      d = a[0] ? legal_out($urandom) : {7'h0, 1'($urandom)};
      if (k[0]) i_host.xfer({1'b0, a, d}, 1'b1, rb);
      else wb(1, {a[5:0], 2'h0}, d, q);
      if (k[0]) wb(0, {a[5:0], 2'h0}, 8'h00, q);
      else i_host.xfer({1'b1, a, 8'h00}, 1'b1, rb);
      chk("reg_rw", {24'h0, d}, k[0] ? q : {24'h0, rb});
    end
    i_host.xfer({1'b0, adc_ctrl_pkg::REG_OUT, 8'h1c}, 1'b1, rb);
    repeat (10) @(posedge clk_i);
    chk("settings", 3'h3, {two_lane_o, drive_low_current_o, term_en_o});
    i_host.xfer({1'b0, adc_ctrl_pkg::REG_OUT, 8'h01}, 1'b0, rb);
    wb(0, 8'h04, 8'h00, q);
    chk("held", 32'h1c, q);
    chk("sdo_low", 0, sdo_o);
    $display("test serial port done");
    // Every lane count and length; counted over whole encode periods.
    for (int t = 0; t < 6; t++) begin
      two = t[0];
      s = 2'(t / 2);
      wb(1, 8'h00, 8'h00, q);
      wb(1, 8'h04, {5'h0, s, two}, q);
      @(posedge lane_clk);
      smp <= {$urandom, $urandom};
      repeat (3) @(posedge enc);
      {fr_cnt, dco_cnt, b_bad, a_act} = 128'h0;
      repeat (20) @(posedge enc);
      chk("fr_count", exp_fr(two, s, 20), fr_cnt);
      chk("lane_b_en", two, lane_b_en_o);
      chk("lane_b_idle", 1, two || b_bad == 0);
      chk("lane_a_busy", 1, a_act > 0);
      chk("dco_runs", 1, dco_cnt > 0);
      chk("overrun", 0, overrun_o);
    end
    // A fast encode leaves too few lane clocks per frame: overrun shows.
    enc_half = 100;
    repeat (8) @(posedge enc);
    chk("overrun_hi", 1, overrun_o);
    enc_half = 800;
    $display("test lanes done");
    // Mode pin is only changed while held in reset.
    @(posedge clk_i);
    rst_i <= 1'b1;
    par <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int v = 0; v < 16; v++) begin
      i_host.strap(4'(v));
      repeat (10) @(posedge clk_i);
      chk("par_two", !v[0], two_lane_o);
      chk("par_ilow", v[1], drive_low_current_o);
      chk("par_pdn", v[2], power_down_o);
      chk("par_term", v[3], term_en_o);
      chk("par_oe_n", 1, sdo_oe_n_o);
      wb(0, 8'h08, 8'h00, q);
      chk("status", {27'h0, v[2], v[3], v[1], !v[0], 1'b1}, q);
    end
    $display("test parallel done");
    tally_and_finish();
  end
endmodule // tb_quad_adc_mode_control_and_lane_select
